// ### rpsc_chk_assertions.sv
// Port-level checks on the radio block outputs
`timescale 1ns/1ps
module rpsc_chk (
    input wire logic        CLK,           // Clock
    input wire logic        SRST,          // Reset
    input wire logic        TX_SELECT_PIN, // Select
    input wire logic        REPEAT_SEND_EN,// Repeat
    input wire logic [1:0]  PA_LEVEL,      // Power code
    input wire logic [8:0]  CHANNEL_INDEX, // Channel
    input wire logic        BAND_DOUBLE,   // Band bit
    input wire logic        MCU_CLK_DIS,   // Clock off
    input wire logic        RX_VALID,      // Byte ready
    input wire logic        CARRIER_SENSE, // Carrier
    input wire logic        ADDR_HIT,      // Hit
    input wire logic        PACKET_DONE,   // Done
    input wire logic        TX_ON,         // Sending
    input wire logic [7:0]  PA_DBM,        // dBm
    input wire logic [19:0] CARRIER_KHZ,   // kHz
    input wire logic        MCU_CLK        // Host clock
);
    localparam logic [7:0] DBM [4] = '{8'hF6, 8'hFE, 8'h06, 8'h0A};
    logic [3:0]  age_q = 4'h0;
    logic [14:0] on_q = 15'h0;
    logic [12:0] pd_q = 13'h0;
    wire logic   up = (age_q == 4'hF);
    // Power, kHz and host clock checks wait for outputs to settle after reset
    always_ff @(posedge CLK) age_q <= SRST ? 4'h0 : age_q + 4'(!up);
    always_ff @(posedge CLK) on_q <= TX_ON ? on_q + 15'h1 : 15'h0;
    always_ff @(posedge CLK) pd_q <= (TX_ON && PACKET_DONE) ? pd_q + 13'h1 : 13'h0;
    default clocking @(posedge CLK); endclocking
    default disable iff (SRST);
    property p_dbm; up |-> PA_DBM == DBM[$past(PA_LEVEL)]; endproperty
    a_dbm: assert property (p_dbm) else $error("power level wrong");
    property p_khz; up |-> CARRIER_KHZ == (20'h67200 + 20'h00064 * 20'($past(CHANNEL_INDEX))) << $past(BAND_DOUBLE);
    endproperty
    a_khz: assert property (p_khz) else $error("carrier kHz wrong");
    property p_cs_off; TX_SELECT_PIN [*4] |-> !CARRIER_SENSE; endproperty
    a_cs_off: assert property (p_cs_off) else $error("carrier sense in tx");
    property p_hit; $rose(PACKET_DONE) && !TX_ON && !$past(TX_ON) |-> $past(ADDR_HIT); endproperty
    a_hit: assert property (p_hit) else $error("done without address hit");
    property p_pre; $fell(PACKET_DONE) && TX_ON |-> pd_q inside {[3990:4210]}; endproperty
    a_pre: assert property (p_pre) else $error("preamble pulse length");
    property p_end; $fell(TX_ON) && !REPEAT_SEND_EN |-> PACKET_DONE && on_q inside {[23190:23410]}; endproperty
    a_end: assert property (p_end) else $error("plain packet end");
    property p_start; $rose(TX_ON) |-> PACKET_DONE == REPEAT_SEND_EN; endproperty
    a_start: assert property (p_start) else $error("done at start");
    property p_drain; $fell(RX_VALID) && !TX_SELECT_PIN |=> !PACKET_DONE && !ADDR_HIT; endproperty
    a_drain: assert property (p_drain) else $error("flags kept");
    property p_mcu; (up && !MCU_CLK_DIS) [*3] |-> MCU_CLK != $past(MCU_CLK, 2); endproperty
    a_mcu: assert property (p_mcu) else $error("host clock stopped");
    c_rx: cover property ($rose(PACKET_DONE) && !TX_ON);
    c_hit: cover property ($rose(ADDR_HIT));
    c_end: cover property ($fell(TX_ON));
endmodule
bind rpsc_top rpsc_chk i_rpsc_chk (.*);

// ### rpsc_fifo.sv
// Flip-flop FIFO, valid/ready both sides, flush
`timescale 1ns/1ps
module rpsc_fifo #(
    parameter int W = 8,
    parameter int D = 4
) (
    input  wire logic         clk,     // Clock
    input  wire logic         srst,    // Sync reset
    input  wire logic         flush,   // Drop all content
    input  wire logic [W-1:0] in_data, // Write data
    input  wire logic         in_valid,// Write request
    output logic              in_ready,// Space available
    output logic [W-1:0]      out_data,// Head word
    output logic              out_valid,// Head word present
    input  wire logic         out_ready // Reader takes head
);
    localparam int AW = $clog2(D);

    logic [W-1:0]  mem_q [D];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0]   cnt_q;
    logic          push;
    logic          pop;

    assign in_ready  = (cnt_q != (AW+1)'(D));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rd_q];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (srst || flush) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(D - 1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(D - 1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// ### rpsc_host.sv
// Host model draining received bytes
`timescale 1ns/1ps
module rpsc_host (
    input  wire logic CLK,      // Clock
    input  wire logic stall,    // Hold off reads
    input  wire logic RX_VALID, // Byte available
    output logic      RX_READY  // Take a byte
);
    logic [1:0] cnt_q = 2'h0;
    initial RX_READY = 1'b0;
    // One read every four cycles
    always @(posedge CLK) begin
        cnt_q <= cnt_q + 2'h1;
        RX_READY <= #1 RX_VALID && !stall && cnt_q == 2'h3;
    end
endmodule

// ### rpsc_pkg.sv
// Constants, carriers and helpers for the radio block
package rpsc_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ       = 20_000_000;
    localparam int CHIP_HZ      = 100_000;
    localparam int CHIP_CYC     = CLK_HZ / CHIP_HZ;
    localparam int MCU_DIV_HALF = 2;

    localparam logic [7:0] CHIP_LAST = 8'(CHIP_CYC - 1);
    localparam logic [7:0] CHIP_MID  = 8'(CHIP_CYC / 2);
    localparam logic [1:0] MCU_LAST  = 2'(MCU_DIV_HALF - 1);

    // ------------------------------------------------------------
    // Packet layout
    // ------------------------------------------------------------
    localparam int PRE_BITS  = 10;
    localparam int ADDR_W    = 8;
    localparam int PAY_W     = 32;
    localparam int CRC_W     = 8;
    localparam int BYTE_W    = 8;
    localparam int PAY_BYTES = PAY_W / BYTE_W;
    localparam int BODY_W    = ADDR_W + PAY_W + CRC_W;
    localparam int FRAME_W   = PRE_BITS + BODY_W;
    localparam int FIFO_DEPTH = 4;

    localparam logic [PRE_BITS-1:0] PREAMBLE = 10'h2AA;
    localparam logic [CRC_W-1:0]    CRC_POLY = 8'h07;
    localparam logic [CRC_W-1:0]    CRC_INIT = 8'hFF;
    localparam logic [5:0]          ADDR_LAST  = 6'(ADDR_W - 1);
    localparam logic [5:0]          CRC_FIRST  = 6'(ADDR_W + PAY_W);
    localparam logic [5:0]          BODY_LAST  = 6'(BODY_W - 1);
    localparam logic [1:0]          BYTE_LAST  = 2'(PAY_BYTES - 1);

    // ------------------------------------------------------------
    // Frequency (kHz) and power table
    // ------------------------------------------------------------
    localparam int KHZ_W = 20;
    localparam logic [KHZ_W-1:0] BASE_KHZ = 20'h67200;
    localparam logic [KHZ_W-1:0] STEP_KHZ = 20'h00064;

    localparam logic [7:0] DBM_P0 = 8'hF6;
    localparam logic [7:0] DBM_P1 = 8'hFE;
    localparam logic [7:0] DBM_P2 = 8'h06;
    localparam logic [7:0] DBM_P3 = 8'h0A;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic pwr;
        logic act;
        logic txsel;
        logic carrier;
        logic chip;
        logic frame;
    } rpsc_pins_t;

    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_PRE  = 2'b01,
        TX_BODY = 2'b11
    } rpsc_tx_t;

    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_BITS = 2'b01,
        RX_PUMP = 2'b11,
        RX_WAIT = 2'b10
    } rpsc_rx_t;

    function automatic logic [CRC_W-1:0] crc_step(input logic [CRC_W-1:0] c, input logic b);
        logic fb;
        fb = c[CRC_W-1] ^ b;
        crc_step = {c[CRC_W-2:0], 1'b0} ^ (fb ? CRC_POLY : '0);
    endfunction

    function automatic logic [CRC_W-1:0] crc_word(input logic [ADDR_W+PAY_W-1:0] d);
        logic [CRC_W-1:0] c;
        c = CRC_INIT;
        for (int i = ADDR_W + PAY_W - 1; i >= 0; i--) begin
            c = crc_step(c, d[i]);
        end
        crc_word = c;
    endfunction

endpackage

// ### rpsc_top.sv
// Radio status and control: framing, coding, status pins
// Notes on behaviour
// - Two-bit power code picks one of four levels
// - Manchester coding both ways, 100k chips per second
// - Carrier kHz from channel index and band bit
// - Step is 100 kHz, or 200 kHz doubled
// - Carrier sense follows carrier during burst receive
// - Address hit raised when received address matches
// - Bad checksum: no done, address hit dropped
// - Plain transmit: done raised after full packet
// - Transmit done cleared on new start or receive
// - Repeat send: done pulses during each preamble
// - Receive done needs address, length and checksum
// - Receive done cleared when drained or transmit
// - Repeat send loops while activate and select high
// - Activate low finishes current packet, then standby
// - Host clock output on after reset unless disabled
// - Ten-bit preamble starts every transmitted packet
// - Power low or select rising edge flush receive state
// - Plain transmit returns to standby, awaits new activate
`timescale 1ns/1ps
module rpsc_top (
    input  wire logic                       CLK,            // 20 MHz clock
    input  wire logic                       SRST,           // Sync reset, high
    input  wire logic                       POWER_ON_PIN,   // Power-up pin
    input  wire logic                       RADIO_ACTIVATE, // Radio enable pin
    input  wire logic                       TX_SELECT_PIN,  // Transmit select pin
    input  wire logic                       RF_CARRIER,     // Carrier present from RF
    input  wire logic                       RF_RX_CHIP,     // Received chip stream
    input  wire logic                       RF_FRAME,       // High while body is received
    input  wire logic                       REPEAT_SEND_EN, // Repeat-send config bit
    input  wire logic [1:0]                 PA_LEVEL,       // Power setting
    input  wire logic [8:0]                 CHANNEL_INDEX,  // Channel index
    input  wire logic                       BAND_DOUBLE,    // Band doubling bit
    input  wire logic                       MCU_CLK_DIS,    // Disable host clock
    input  wire logic [7:0]                 RX_ADDR,        // Own address
    input  wire logic [7:0]                 TX_ADDR,        // Destination address
    input  wire logic [31:0]                TX_PAYLOAD,     // Transmit payload
    input  wire logic                       RX_READY,       // Host takes a byte
    output logic [7:0]                      RX_DATA,        // Received byte
    output logic                            RX_VALID,       // Byte available
    output logic                            CARRIER_SENSE,  // Carrier status
    output logic                            ADDR_HIT,       // Address match status
    output logic                            PACKET_DONE,    // Packet done status
    output logic                            TX_CHIP,        // Transmit chip stream
    output logic                            TX_ON,          // Transmitter active
    output logic [7:0]                      PA_DBM,         // Power in dBm, signed
    output logic [rpsc_pkg::KHZ_W-1:0]      CARRIER_KHZ,    // Carrier in kHz
    output logic                            MCU_CLK         // Host clock output
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    rpsc_pkg::rpsc_pins_t pin_s1_q;
    rpsc_pkg::rpsc_pins_t pin_q;
    rpsc_pkg::rpsc_pins_t pin_prev_q;

    always_ff @(posedge CLK) begin
        if (SRST) begin
            pin_s1_q   <= '0;
            pin_q      <= '0;
            pin_prev_q <= '0;
        end else begin
            pin_s1_q   <= {POWER_ON_PIN, RADIO_ACTIVATE, TX_SELECT_PIN, RF_CARRIER, RF_RX_CHIP, RF_FRAME};
            pin_q      <= pin_s1_q;
            pin_prev_q <= pin_q;
        end
    end

    logic rx_mode;
    logic tx_mode;
    logic flush_rx;
    logic frame_rise;

    assign rx_mode    = pin_q.pwr && pin_q.act && !pin_q.txsel;
    assign tx_mode    = pin_q.pwr && pin_q.act && pin_q.txsel;
    assign flush_rx   = !pin_q.pwr || (pin_q.txsel && !pin_prev_q.txsel);
    assign frame_rise = pin_q.frame && !pin_prev_q.frame;

    // ------------------------------------------------------------
    // Configuration outputs
    // ------------------------------------------------------------
    logic [rpsc_pkg::KHZ_W-1:0] khz_lin;

    assign khz_lin = rpsc_pkg::BASE_KHZ + rpsc_pkg::KHZ_W'(CHANNEL_INDEX) * rpsc_pkg::STEP_KHZ;

    always_ff @(posedge CLK) begin
        if (SRST) begin
            CARRIER_KHZ <= '0;
            PA_DBM      <= rpsc_pkg::DBM_P0;
        end else begin
            CARRIER_KHZ <= BAND_DOUBLE ? rpsc_pkg::KHZ_W'(khz_lin << 1) : khz_lin;
            unique case (PA_LEVEL)
                2'h0: PA_DBM <= rpsc_pkg::DBM_P0;
                2'h1: PA_DBM <= rpsc_pkg::DBM_P1;
                2'h2: PA_DBM <= rpsc_pkg::DBM_P2;
                2'h3: PA_DBM <= rpsc_pkg::DBM_P3;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Host clock
    // ------------------------------------------------------------
    logic [1:0] mcu_cnt_q;

    always_ff @(posedge CLK) begin
        if (SRST) begin
            mcu_cnt_q <= '0;
            MCU_CLK   <= 1'b0;
        end else if (MCU_CLK_DIS) begin
            mcu_cnt_q <= '0;
            MCU_CLK   <= 1'b0;
        end else if (mcu_cnt_q == rpsc_pkg::MCU_LAST) begin
            mcu_cnt_q <= '0;
            MCU_CLK   <= !MCU_CLK;
        end else begin
            mcu_cnt_q <= mcu_cnt_q + 2'h1;
        end
    end

    // ------------------------------------------------------------
    // Chip-rate enable
    // ------------------------------------------------------------
    rpsc_pkg::rpsc_tx_t tx_state_q;
    rpsc_pkg::rpsc_rx_t rx_state_q;
    logic [7:0]         chip_cnt_q;
    logic               chip_en;
    logic               rx_align;

    assign chip_en  = (chip_cnt_q == '0);
    // Realign to mid-chip on frame edge
    assign rx_align = frame_rise && rx_mode && (rx_state_q == rpsc_pkg::RX_IDLE);

    always_ff @(posedge CLK) begin
        if (SRST) begin
            chip_cnt_q <= rpsc_pkg::CHIP_LAST;
        end else if (rx_align) begin
            chip_cnt_q <= rpsc_pkg::CHIP_MID;
        end else if (chip_en) begin
            chip_cnt_q <= rpsc_pkg::CHIP_LAST;
        end else begin
            chip_cnt_q <= chip_cnt_q - 8'h01;
        end
    end

    // ------------------------------------------------------------
    // Transmitter
    // ------------------------------------------------------------
    logic [rpsc_pkg::FRAME_W-1:0] tx_sh_q;
    logic [5:0]                   tx_cnt_q;
    logic                         tx_ph_q;
    logic                         tx_go_q;
    logic                         tx_step;
    logic                         tx_last;
    logic                         tx_pre_end;
    logic                         tx_fresh;
    logic                         tx_restart;

    // Bit boundaries: ends are seen only after the second chip has stood its time
    assign tx_step    = (tx_state_q != rpsc_pkg::TX_IDLE) && chip_en && !tx_ph_q;
    assign tx_last    = tx_step && (tx_cnt_q == 6'(rpsc_pkg::FRAME_W));
    assign tx_pre_end = tx_step && (tx_cnt_q == 6'(rpsc_pkg::PRE_BITS));
    // Fresh start needs a new activate-with-select edge
    assign tx_fresh   = (tx_state_q == rpsc_pkg::TX_IDLE) && tx_mode && !tx_go_q;
    assign tx_restart = tx_last && REPEAT_SEND_EN && tx_mode;

    always_ff @(posedge CLK) begin
        if (SRST) begin
            tx_go_q <= 1'b0;
        end else begin
            tx_go_q <= tx_mode;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST || !pin_q.pwr) begin
            tx_state_q <= rpsc_pkg::TX_IDLE;
            tx_sh_q    <= '0;
            tx_cnt_q   <= '0;
            tx_ph_q    <= 1'b0;
            TX_CHIP    <= 1'b0;
            TX_ON      <= 1'b0;
        end else if (tx_fresh || tx_restart) begin
            tx_state_q <= rpsc_pkg::TX_PRE;
            tx_sh_q    <= {rpsc_pkg::PREAMBLE, TX_ADDR, TX_PAYLOAD,
                           rpsc_pkg::crc_word({TX_ADDR, TX_PAYLOAD})};
            tx_cnt_q   <= '0;
            tx_ph_q    <= 1'b0;
            TX_ON      <= 1'b1;
        end else if (tx_last) begin
            tx_state_q <= rpsc_pkg::TX_IDLE;
            tx_ph_q    <= 1'b0;
            TX_CHIP    <= 1'b0;
            TX_ON      <= 1'b0;
        end else if (tx_state_q != rpsc_pkg::TX_IDLE && chip_en) begin
            // One: high then low; zero: low then high
            TX_CHIP <= tx_ph_q ? !tx_sh_q[rpsc_pkg::FRAME_W-1] : tx_sh_q[rpsc_pkg::FRAME_W-1];
            tx_ph_q <= !tx_ph_q;
            if (tx_ph_q) begin
                tx_sh_q  <= {tx_sh_q[rpsc_pkg::FRAME_W-2:0], 1'b0};
                tx_cnt_q <= tx_cnt_q + 6'h01;
            end
            if (tx_pre_end) begin
                tx_state_q <= rpsc_pkg::TX_BODY;
            end
        end
    end

    // ------------------------------------------------------------
    // Receiver
    // ------------------------------------------------------------
    logic [rpsc_pkg::BODY_W-1:0]  rx_sh_q;
    logic [rpsc_pkg::CRC_W-1:0]   rx_crc_q;
    logic [5:0]                   rx_cnt_q;
    logic                         rx_ph_q;
    logic                         rx_first_q;
    logic                         rx_err_q;
    logic [1:0]                   rx_idx_q;
    logic                         rx_bit_en;
    logic                         rx_bit;
    logic                         rx_body_end;
    logic                         rx_good;
    logic                         rx_fail;
    logic                         rx_addr_ok;
    logic                         rx_drained;
    logic                         fifo_in_ready;
    logic                         fifo_valid;
    logic [rpsc_pkg::BYTE_W-1:0]  fifo_in;

    assign rx_bit_en   = (rx_state_q == rpsc_pkg::RX_BITS) && chip_en && rx_ph_q;
    assign rx_bit      = rx_first_q;
    assign rx_body_end = rx_bit_en && (rx_cnt_q == rpsc_pkg::BODY_LAST);
    assign rx_addr_ok  = ({rx_sh_q[rpsc_pkg::ADDR_W-2:0], rx_bit} == RX_ADDR);
    assign rx_good     = rx_body_end && ADDR_HIT && !rx_err_q && (pin_q.chip != rx_first_q)
                         && ({rx_sh_q[rpsc_pkg::CRC_W-2:0], rx_bit} == rx_crc_q);
    // Failure: checksum, coding, early frame end, mode left
    assign rx_fail     = (rx_state_q == rpsc_pkg::RX_BITS)
                         && ((rx_body_end && !rx_good) || !pin_q.frame || !rx_mode);
    assign rx_drained  = (rx_state_q == rpsc_pkg::RX_WAIT) && !fifo_valid;
    assign fifo_in     = rx_sh_q[rpsc_pkg::BODY_W-rpsc_pkg::ADDR_W-1 - rpsc_pkg::BYTE_W*rx_idx_q -: rpsc_pkg::BYTE_W];

    always_ff @(posedge CLK) begin
        if (SRST || flush_rx) begin
            rx_state_q <= rpsc_pkg::RX_IDLE;
            rx_sh_q    <= '0;
            rx_crc_q   <= rpsc_pkg::CRC_INIT;
            rx_cnt_q   <= '0;
            rx_ph_q    <= 1'b0;
            rx_first_q <= 1'b0;
            rx_err_q   <= 1'b0;
            rx_idx_q   <= '0;
        end else begin
            unique case (rx_state_q)
                rpsc_pkg::RX_IDLE: begin
                    if (rx_align) begin
                        rx_state_q <= rpsc_pkg::RX_BITS;
                        rx_crc_q   <= rpsc_pkg::CRC_INIT;
                        rx_cnt_q   <= '0;
                        rx_ph_q    <= 1'b0;
                        rx_err_q   <= 1'b0;
                    end
                end
                rpsc_pkg::RX_BITS: begin
                    if (rx_good) begin
                        rx_state_q <= rpsc_pkg::RX_PUMP;
                        rx_idx_q   <= '0;
                        rx_sh_q    <= {rx_sh_q[rpsc_pkg::BODY_W-2:0], rx_bit};
                    end else if (rx_fail) begin
                        rx_state_q <= rpsc_pkg::RX_IDLE;
                    end else if (chip_en) begin
                        rx_ph_q <= !rx_ph_q;
                        if (!rx_ph_q) begin
                            rx_first_q <= pin_q.chip;
                        end else begin
                            rx_err_q <= rx_err_q || (pin_q.chip == rx_first_q);
                            rx_sh_q  <= {rx_sh_q[rpsc_pkg::BODY_W-2:0], rx_bit};
                            rx_cnt_q <= rx_cnt_q + 6'h01;
                            if (rx_cnt_q < rpsc_pkg::CRC_FIRST) begin
                                rx_crc_q <= rpsc_pkg::crc_step(rx_crc_q, rx_bit);
                            end
                        end
                    end
                end
                rpsc_pkg::RX_PUMP: begin
                    // Hold payload until FIFO takes every byte
                    if (fifo_in_ready) begin
                        rx_idx_q <= rx_idx_q + 2'h1;
                        if (rx_idx_q == rpsc_pkg::BYTE_LAST) begin
                            rx_state_q <= rpsc_pkg::RX_WAIT;
                        end
                    end
                end
                rpsc_pkg::RX_WAIT: begin
                    if (rx_drained) begin
                        rx_state_q <= rpsc_pkg::RX_IDLE;
                    end
                end
            endcase
        end
    end

    rpsc_fifo #(
        .W (rpsc_pkg::BYTE_W),
        .D (rpsc_pkg::FIFO_DEPTH)
    ) u_rx_fifo (
        .clk       (CLK),
        .srst      (SRST),
        .flush     (flush_rx),
        .in_data   (fifo_in),
        .in_valid  (rx_state_q == rpsc_pkg::RX_PUMP),
        .in_ready  (fifo_in_ready),
        .out_data  (RX_DATA),
        .out_valid (fifo_valid),
        .out_ready (RX_READY)
    );

    assign RX_VALID = fifo_valid;

    // ------------------------------------------------------------
    // Status pins
    // ------------------------------------------------------------
    logic done_tx_q;

    always_ff @(posedge CLK) begin
        if (SRST) begin
            CARRIER_SENSE <= 1'b0;
        end else begin
            CARRIER_SENSE <= rx_mode && pin_q.carrier;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST) begin
            ADDR_HIT <= 1'b0;
        end else if (rx_bit_en && rx_cnt_q == rpsc_pkg::ADDR_LAST && rx_addr_ok && !flush_rx) begin
            ADDR_HIT <= 1'b1;
        end else if (flush_rx || rx_fail || rx_drained) begin
            ADDR_HIT <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (SRST || !pin_q.pwr) begin
            PACKET_DONE <= 1'b0;
            done_tx_q   <= 1'b0;
        end else if (tx_fresh || tx_restart) begin
            PACKET_DONE <= REPEAT_SEND_EN;
            done_tx_q   <= 1'b1;
        end else if (tx_last) begin
            PACKET_DONE <= 1'b1;
        end else if (tx_pre_end && REPEAT_SEND_EN) begin
            PACKET_DONE <= 1'b0;
        end else if (rx_good && !flush_rx) begin
            PACKET_DONE <= 1'b1;
            done_tx_q   <= 1'b0;
        end else if (done_tx_q ? rx_mode : (flush_rx || rx_drained)) begin
            PACKET_DONE <= 1'b0;
        end
    end

endmodule

// ### test_rpsc_top.sv
// Self-checking bench for the radio block
`timescale 1ns/1ps
module test_rpsc_top;
    logic        CLK = 1'b0, SRST = 1'b1, POWER_ON_PIN = 1'b0, RADIO_ACTIVATE = 1'b0, TX_SELECT_PIN = 1'b0;
    logic        RF_CARRIER = 1'b0, RF_RX_CHIP = 1'b0, RF_FRAME = 1'b0, REPEAT_SEND_EN = 1'b0, BAND_DOUBLE = 1'b0;
    logic        MCU_CLK_DIS = 1'b0, stall = 1'b0, RX_READY, RX_VALID, CARRIER_SENSE, ADDR_HIT, PACKET_DONE, TX_CHIP;
    logic        TX_ON, MCU_CLK;
    logic [1:0]  PA_LEVEL = 2'h0;
    logic [8:0]  CHANNEL_INDEX = 9'h000;
    logic [7:0]  RX_ADDR = 8'h00, TX_ADDR = 8'h00, RX_DATA, PA_DBM, exp_q [$];
    logic [7:0]  dbm [4] = '{8'hF6, 8'hFE, 8'h06, 8'h0A};
    logic [31:0] TX_PAYLOAD = 32'h0, seed = 32'h3867;
    logic [19:0] CARRIER_KHZ;
    int          num_errors = 0, comparisons = 0;
    rpsc_top  i_rpsc_top (.*);
    rpsc_host i_rpsc_host (.CLK, .stall, .RX_VALID, .RX_READY);
    always #25 CLK = ~CLK;
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [7:0] crc8(input logic [39:0] d);
        logic [7:0] c;
        c = 8'hFF;
        for (int i = 39; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
        return c;
    endfunction
    task cyc(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask
    task chk(input logic [31:0] e, input logic [31:0] s, input string n);
        comparisons++;
        if (s !== e) begin
            num_errors++;
            $display("MISMATCH %s expected %0h seen %0h", n, e, s);
        end
    endtask
    task final_report();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    always @(negedge CLK) if (RX_VALID === 1'b1 && RX_READY === 1'b1) begin
        if (exp_q.size() == 0) chk(32'h0, 32'h1, "extra byte");
        else chk(exp_q.pop_front(), RX_DATA, "rx byte");
    end
    task rx_pkt(input logic good);
        logic [47:0] w;
        w[47:8] = {RX_ADDR, rnd()};
        w[7:0] = crc8(w[47:8]) ^ {7'h00, !good};
        stall = 1'b1;
        RF_FRAME = 1'b1;
        for (int i = 47; i >= 0; i--) begin
            RF_RX_CHIP = w[i];
            cyc(200);
            if (i == 39) chk(32'h1, ADDR_HIT, "addr hit");
            RF_RX_CHIP = !w[i];
            cyc(200);
        end
        RF_FRAME = 1'b0;
        RF_RX_CHIP = w[0];
        cyc(300);
        chk({30'h0, good, good}, {PACKET_DONE, ADDR_HIT}, "rx end");
        if (good) for (int k = 3; k >= 0; k--) exp_q.push_back(w[8+8*k +: 8]);
        stall = 1'b0;
        cyc(40);
        chk(32'h0, {exp_q.size(), RX_VALID, PACKET_DONE, ADDR_HIT}, "drained");
    endtask
    task tx_pkt(input logic rep);
        logic [57:0] f;
        TX_ADDR = 8'(rnd());
        TX_PAYLOAD = rnd();
        REPEAT_SEND_EN = rep;
        f = {10'h2AA, TX_ADDR, TX_PAYLOAD, crc8({TX_ADDR, TX_PAYLOAD})};
        TX_SELECT_PIN = 1'b1;
        for (int t = 0; t < 400 && TX_CHIP !== 1'b1; t++) cyc(1);
        cyc(100);
        for (int j = 57; j >= 0; j--) begin
            chk(f[j], TX_CHIP, "tx chip");
            cyc(200);
            chk(!f[j], TX_CHIP, "tx chip 2");
            cyc(200);
        end
        if (!rep) begin
            chk(32'h1, {TX_ON, PACKET_DONE}, "plain end");
            cyc(1000);
            chk(32'h0, TX_ON, "no resend");
        end else begin
            chk(32'h3, {TX_ON, PACKET_DONE}, "resend");
            cyc(4200);
            chk(32'h0, PACKET_DONE, "pulse over");
            RADIO_ACTIVATE = 1'b0;
            cyc(2000);
            chk(32'h1, TX_ON, "finish packet");
            for (int t = 0; t < 20000 && TX_ON !== 1'b0; t++) cyc(1);
            chk(32'h0, TX_ON, "standby");
        end
    endtask
    initial begin
        cyc(10);
        SRST = 1'b0;
        POWER_ON_PIN = 1'b1;
        RADIO_ACTIVATE = 1'b1;
        RX_ADDR = 8'(rnd());
        for (int k = 0; k < 8; k++) begin
            PA_LEVEL = 2'(k);
            {BAND_DOUBLE, CHANNEL_INDEX} = 10'(rnd());
            cyc(3);
            chk(dbm[PA_LEVEL], PA_DBM, "power");
            chk((20'h67200 + 20'h00064 * CHANNEL_INDEX) << BAND_DOUBLE, CARRIER_KHZ, "khz");
        end
        RF_CARRIER = 1'b1;
        cyc(6);
        chk(32'h1, CARRIER_SENSE, "carrier on");
        RF_CARRIER = 1'b0;
        cyc(6);
        chk(32'h0, CARRIER_SENSE, "channel free");
        rx_pkt(1'b1);
        rx_pkt(1'b0);
        RF_CARRIER = 1'b1;
        tx_pkt(1'b0);
        chk(32'h0, CARRIER_SENSE, "tx carrier");
        TX_SELECT_PIN = 1'b0;
        cyc(6);
        chk(32'h0, PACKET_DONE, "rx clears");
        tx_pkt(1'b1);
        final_report();
    end
    initial begin
        repeat (150000) @(posedge CLK);
        num_errors++;
        final_report();
    end
endmodule
